// [verilog/nsop_top.sv]
// Oscillator selection from pins, phase accumulators and fast overrange flags.
// Assumes select pins asynchronous, samples synchronous to clk_sys_in, Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none
module nsop_top (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Avalon-MM slave
   input wire logic [nsop_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Select pins
   input wire logic osc_sel_a_bit0_in,
   input wire logic osc_sel_a_bit1_in,
   input wire logic osc_sel_b_bit0_in,
   input wire logic osc_sel_b_bit1_in,
   // Samples
   input wire logic [nsop_pkg::SAMP_W-1:0] sample_a_in,
   input wire logic [nsop_pkg::SAMP_W-1:0] sample_b_in,
   // Mixer phase and flags
   output logic [nsop_pkg::PHASE_W-1:0] mix_phase_a_out,
   output logic [nsop_pkg::PHASE_W-1:0] mix_phase_b_out,
   output logic mix_enable_out,
   output logic ovr_flag_a_first_out,
   output logic ovr_flag_a_second_out,
   output logic ovr_flag_b_first_out,
   output logic ovr_flag_b_second_out,
   output logic irq_out
);
   localparam int PW = nsop_pkg::PHASE_W;
   localparam int HW = nsop_pkg::HOLD_W;
   localparam int MW = nsop_pkg::MAG_W;

   // Magnitude of a two's complement sample, saturated at full scale
   function automatic logic [MW-1:0] mag_of(input logic [nsop_pkg::SAMP_W-1:0] s);
      logic [nsop_pkg::SAMP_W-1:0] n;
      n = '0;
      if (s[nsop_pkg::SAMP_W-1]) begin
         n = ~s + 12'h001;
         if (n[nsop_pkg::SAMP_W-1]) begin
            mag_of = '1;
         end else begin
            mag_of = n[MW-1:0];
         end
      end else begin
         mag_of = s[MW-1:0];
      end
   endfunction

   // Hold counter step: reload on trip, else count down
   function automatic logic [HW-1:0] hold_next(input logic trip, input logic [HW-1:0] cnt,
                                                input logic [HW-1:0] len);
      if (trip) begin
         hold_next = len;
      end else if (cnt != '0) begin
         hold_next = cnt - 8'h01;
      end else begin
         hold_next = '0;
      end
   endfunction

   // ---------------- Registers ----------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [MW-1:0] thr1_q, thr1_d, thr2_q, thr2_d;
   logic [HW-1:0] hold_len_q, hold_len_d;
   logic [PW-1:0] freq_q [2*nsop_pkg::NUM_OSC];
   logic [PW-1:0] freq_d [2*nsop_pkg::NUM_OSC];
   logic [3:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d;
   logic [31:0] rdata_q, rdata_d;
   logic wait_q, wait_d;
   logic irq_q, irq_d;

   // ---------------- Select path ----------------
   nsop_pkg::nsop_sel_type sync1_q, sync2_q, act_q, act_d;
   logic [PW-1:0] acc_q [2*nsop_pkg::NUM_OSC];
   logic [PW-1:0] acc_d [2*nsop_pkg::NUM_OSC];
   logic [PW-1:0] pha_q, pha_d, phb_q, phb_d;
   logic mix_q, mix_d;

   // ---------------- Overrange path ----------------
   nsop_pkg::nsop_ovr_type ovra_q, ovra_d, ovrb_q, ovrb_d;
   logic [HW-1:0] ha1_q, ha1_d, ha2_q, ha2_d, hb1_q, hb1_d, hb2_q, hb2_d;
   logic ta1, ta2, tb1, tb2;
   logic [MW-1:0] mag_a, mag_b;

   logic access, wr_go, rd_go;
   logic [3:0] events;

   assign access = (avs_read_in | avs_write_in) & wait_q;
   assign wr_go = avs_write_in & wait_q;
   assign rd_go = avs_read_in & wait_q;

   // Bus, configuration and interrupts
   always_comb begin
      ctrl_d = ctrl_q;
      thr1_d = thr1_q;
      thr2_d = thr2_q;
      hold_len_d = hold_len_q;
      irq_mask_d = irq_mask_q;
      freq_d = freq_q;
      rdata_d = rdata_q;
      wait_d = 1'b1;
      if (access) begin
         wait_d = 1'b0;
      end
      if (wr_go) begin
         if (avs_address_in == nsop_pkg::REG_CTRL) begin
            if (avs_byteenable_in[0]) begin
               ctrl_d[7:0] = avs_writedata_in[7:0];
            end
         end else if (avs_address_in == nsop_pkg::REG_THR) begin
            if (avs_byteenable_in[1:0] == 2'h3) begin
               thr1_d = avs_writedata_in[MW-1:0];
            end
            if (avs_byteenable_in[3:2] == 2'h3) begin
               thr2_d = avs_writedata_in[nsop_pkg::THR_SECOND_LSB +: MW];
            end
         end else if (avs_address_in == nsop_pkg::REG_HOLD) begin
            if (avs_byteenable_in[0]) begin
               hold_len_d = avs_writedata_in[HW-1:0];
            end
         end else if (avs_address_in == nsop_pkg::REG_IRQ_MASK) begin
            if (avs_byteenable_in[0]) begin
               irq_mask_d = avs_writedata_in[3:0];
            end
         end else if (avs_address_in[3]) begin
            if (avs_byteenable_in == 4'hf) begin
               freq_d[avs_address_in[2:0]] = avs_writedata_in;
            end
         end
      end
      if (rd_go) begin
         rdata_d = 32'h0000_0000;
         if (avs_address_in == nsop_pkg::REG_CTRL) begin
            rdata_d = {24'h00_0000, ctrl_q[7:0]};
         end else if (avs_address_in == nsop_pkg::REG_THR) begin
            rdata_d = {5'h00, thr2_q, 5'h00, thr1_q};
         end else if (avs_address_in == nsop_pkg::REG_HOLD) begin
            rdata_d = {24'h00_0000, hold_len_q};
         end else if (avs_address_in == nsop_pkg::REG_STATUS) begin
            rdata_d = {20'h0_0000, act_q.a, act_q.b, 4'h0,
                       ovra_q.first, ovra_q.second, ovrb_q.first, ovrb_q.second};
         end else if (avs_address_in == nsop_pkg::REG_IRQ_STAT) begin
            rdata_d = {28'h000_0000, irq_stat_q};
         end else if (avs_address_in == nsop_pkg::REG_IRQ_MASK) begin
            rdata_d = {28'h000_0000, irq_mask_q};
         end else if (avs_address_in[3]) begin
            rdata_d = freq_q[avs_address_in[2:0]];
         end
      end
      // Rising edges of the flags; set wins over a write-one clear
      events = {ta1 & ~ovra_q.first, ta2 & ~ovra_q.second,
                tb1 & ~ovrb_q.first, tb2 & ~ovrb_q.second};
      irq_stat_d = irq_stat_q;
      if (wr_go && avs_address_in == nsop_pkg::REG_IRQ_STAT && avs_byteenable_in[0]) begin
         irq_stat_d = irq_stat_q & ~avs_writedata_in[3:0];
      end
      irq_stat_d = irq_stat_d | events;
      irq_d = |(irq_stat_d & irq_mask_d);
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ctrl_q <= nsop_pkg::CTRL_RESET;
         thr1_q <= nsop_pkg::THR_FIRST_RESET;
         thr2_q <= nsop_pkg::THR_SECOND_RESET;
         hold_len_q <= nsop_pkg::HOLD_RESET;
         irq_mask_q <= nsop_pkg::IRQ_MASK_RESET;
         irq_stat_q <= 4'h0;
         for (int i = 0; i < 2*nsop_pkg::NUM_OSC; i++) begin
            freq_q[i] <= nsop_pkg::FREQ_RESET;
         end
         rdata_q <= 32'h0000_0000;
         wait_q <= 1'b1;
         irq_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         thr1_q <= thr1_d;
         thr2_q <= thr2_d;
         hold_len_q <= hold_len_d;
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         freq_q <= freq_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         irq_q <= irq_d;
      end
   end

   // Oscillators, selection and mixing phase
   always_comb begin
      for (int i = 0; i < 2*nsop_pkg::NUM_OSC; i++) begin
         acc_d[i] = acc_q[i] + freq_q[i]; // R4
      end
      act_d = act_q;
      if (ctrl_q[nsop_pkg::CTRL_SRC_BIT]) begin
         act_d = sync2_q; // R5
      end else begin
         act_d.a = ctrl_q[nsop_pkg::CTRL_SELA_LSB +: 2];
         act_d.b = ctrl_q[nsop_pkg::CTRL_SELB_LSB +: 2];
      end
      mix_d = ctrl_q[nsop_pkg::CTRL_CPLX_BIT]; // R3
      pha_d = '0;
      phb_d = '0;
      if (mix_d) begin
         pha_d = acc_q[{1'b0, act_q.a}]; // R2
         phb_d = acc_q[{1'b1, act_q.b}]; // R2
      end
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         act_q <= '0;
         for (int i = 0; i < 2*nsop_pkg::NUM_OSC; i++) begin
            acc_q[i] <= '0;
         end
         pha_q <= '0;
         phb_q <= '0;
         mix_q <= 1'b0;
      end else begin
         sync1_q <= {osc_sel_a_bit1_in, osc_sel_a_bit0_in,
                     osc_sel_b_bit1_in, osc_sel_b_bit0_in}; // R1
         sync2_q <= sync1_q; // R6
         act_q <= act_d;
         acc_q <= acc_d;
         pha_q <= pha_d;
         phb_q <= phb_d;
         mix_q <= mix_d;
      end
   end

   // Overrange detection and hold
   always_comb begin
      mag_a = mag_of(sample_a_in); // R11
      mag_b = mag_of(sample_b_in); // R11
      ta1 = mag_a > thr1_q; // R8
      ta2 = mag_a > thr2_q; // R9
      tb1 = mag_b > thr1_q; // R8
      tb2 = mag_b > thr2_q; // R9
      ha1_d = hold_next(ta1, ha1_q, hold_len_q); // R10
      ha2_d = hold_next(ta2, ha2_q, hold_len_q);
      hb1_d = hold_next(tb1, hb1_q, hold_len_q);
      hb2_d = hold_next(tb2, hb2_q, hold_len_q);
      ovra_d.first = ta1 | (ha1_q > 8'h01); // R10
      ovra_d.second = ta2 | (ha2_q > 8'h01);
      ovrb_d.first = tb1 | (hb1_q > 8'h01);
      ovrb_d.second = tb2 | (hb2_q > 8'h01);
   end

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ha1_q <= '0;
         ha2_q <= '0;
         hb1_q <= '0;
         hb2_q <= '0;
         ovra_q <= '0;
         ovrb_q <= '0;
      end else begin
         ha1_q <= ha1_d;
         ha2_q <= ha2_d;
         hb1_q <= hb1_d;
         hb2_q <= hb2_d;
         ovra_q <= ovra_d;
         ovrb_q <= ovrb_d;
      end
   end

   assign avs_readdata_out = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign mix_phase_a_out = pha_q;
   assign mix_phase_b_out = phb_q;
   assign mix_enable_out = mix_q;
   assign ovr_flag_a_first_out = ovra_q.first;
   assign ovr_flag_a_second_out = ovra_q.second;
   assign ovr_flag_b_first_out = ovrb_q.first;
   assign ovr_flag_b_second_out = ovrb_q.second;
   assign irq_out = irq_q;
endmodule
`default_nettype wire

// [verilog/nsop_pkg.sv]
// Constants, register map and carrier types for oscillator select and overrange flags.
// Assumes one system clock; samples arrive synchronously, one per channel per cycle.
// Behaviour
// [R1] Each down-converter forms a 2-bit oscillator index from its two select pins, bit 0 being the least significant.
// [R2] Channel A and channel B have separate select pins and separate oscillator choices.
// [R3] The chosen oscillator is applied to mixing only in a complex output mode.
// [R4] Every oscillator advances its phase every cycle whether chosen or not.
// [R5] Select pin changes switch the oscillator only while the select source setting is 1.
// [R6] Select pins are asynchronous and are resynchronised before use.
// [R7] The host holds unused select pins low.
// [R8] Each channel drives a first overrange flag while sample magnitude exceeds the first threshold.
// [R9] Each channel drives a second overrange flag while sample magnitude exceeds the second threshold.
// [R10] An asserted overrange flag stays high for at least the programmed hold length.
// [R11] The overrange comparison uses sample magnitude, so both polarities trip it.
package nsop_pkg;
   localparam int ADDR_W = 4;
   localparam int SAMP_W = 12;
   localparam int MAG_W = 11;
   localparam int PHASE_W = 32;
   localparam int HOLD_W = 8;
   localparam int NUM_OSC = 4;
   // Word offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_THR = 4'h1;
   localparam logic [3:0] REG_HOLD = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_IRQ_STAT = 4'h4;
   localparam logic [3:0] REG_IRQ_MASK = 4'h5;
   localparam logic [3:0] REG_FREQ0 = 4'h8;
   // Control and threshold fields
   localparam int CTRL_SRC_BIT = 0;
   localparam int CTRL_CPLX_BIT = 1;
   localparam int CTRL_SELA_LSB = 4;
   localparam int CTRL_SELB_LSB = 6;
   localparam int THR_SECOND_LSB = 16;
   // Reset values
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [MAG_W-1:0] THR_FIRST_RESET = 11'h7ff;
   localparam logic [MAG_W-1:0] THR_SECOND_RESET = 11'h7ff;
   localparam logic [HOLD_W-1:0] HOLD_RESET = 8'h01;
   localparam logic [PHASE_W-1:0] FREQ_RESET = 32'h0000_0000;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
   // Fixed single wait state on every bus access
   localparam int BUS_WAIT_CYCLES = 1;

   typedef struct packed {
      logic first;
      logic second;
   } nsop_ovr_type;

   typedef struct packed {
      logic [1:0] a;
      logic [1:0] b;
   } nsop_sel_type;
endpackage

// [test/nsop_sva.sv]
// Checker for oscillator select and overrange flags at the nsop_top ports.
// Assumes register writes carry all four byte enables.
`timescale 1ns/1ns
`default_nettype none
module nsop_sva (
   // Clock, reset and bus
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [3:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Samples, mixer and flags
   input wire logic [11:0] sample_a_in,
   input wire logic [11:0] sample_b_in,
   input wire logic [31:0] mix_phase_a_out,
   input wire logic mix_enable_out,
   input wire logic ovr_flag_a_first_out,
   input wire logic ovr_flag_b_second_out
);
   logic [10:0] thr1_q, thr2_q;
   logic [7:0] hold_q;
   logic [8:0] cnt_q;
   logic trip_q;
   wire wr_ok = avs_write_in && !avs_waitrequest_out;
   function automatic logic [10:0] mag(input logic [11:0] s);
      return (s == 12'h800) ? 11'h7ff : (s[11] ? 11'(-s) : s[10:0]);
   endfunction
   // Shadow of threshold and hold registers
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         thr1_q <= 11'h7ff;
         thr2_q <= 11'h7ff;
         hold_q <= 8'h01;
         cnt_q <= 9'h000;
         trip_q <= 1'b0;
      end else begin
         cnt_q <= ovr_flag_a_first_out ? cnt_q + 9'h001 : 9'h000;
         trip_q <= mag(sample_a_in) > thr1_q;
         if (wr_ok && avs_address_in == nsop_pkg::REG_THR) begin
            thr1_q <= avs_writedata_in[10:0];
            thr2_q <= avs_writedata_in[26:16];
         end
         if (wr_ok && avs_address_in == nsop_pkg::REG_HOLD) begin
            hold_q <= avs_writedata_in[7:0];
         end
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_ack;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> s_ack)
      else $error("bus answer not one cycle");
   a_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low too long");
   a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
      && avs_address_in inside {4'h6, 4'h7} |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_mix_gated: assert property (!mix_enable_out |-> mix_phase_a_out == 32'h0)
      else $error("phase outside complex mode");
   a_trip_first: assert property (mag(sample_a_in) > thr1_q |=> ovr_flag_a_first_out)
      else $error("first flag missed");
   a_trip_second: assert property (mag(sample_b_in) > thr2_q |=> ovr_flag_b_second_out)
      else $error("second flag missed");
   a_flag_cause: assert property ($rose(ovr_flag_a_first_out) |-> trip_q)
      else $error("flag rose without trip");
   a_hold_min: assert property ($fell(ovr_flag_a_first_out) |-> cnt_q >= {1'b0, hold_q})
      else $error("flag shorter than hold");
endmodule
bind nsop_top nsop_sva chk_u (.clk_sys_in, .reset_n_in, .avs_address_in, .avs_read_in,
   .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .sample_a_in,
   .sample_b_in, .mix_phase_a_out, .mix_enable_out, .ovr_flag_a_first_out,
   .ovr_flag_b_second_out);
`default_nettype wire

// [test/nsop_host_model.sv]
// Host logic driving the oscillator select pins.
// Pins move on the falling edge, half a cycle away from the sampling edge.
`timescale 1ns/1ns
`default_nettype none
module nsop_host_model (
   // Clock and request
   input wire logic clk_sys_in,
   input wire nsop_pkg::nsop_sel_type sel_in,
   // Select pins
   output logic osc_sel_a_bit0_out,
   output logic osc_sel_a_bit1_out,
   output logic osc_sel_b_bit0_out,
   output logic osc_sel_b_bit1_out
);
   // Unused pins stay low unless requested
   initial {osc_sel_a_bit1_out, osc_sel_a_bit0_out, osc_sel_b_bit1_out, osc_sel_b_bit0_out} = 4'h0;
   always @(negedge clk_sys_in) begin
      {osc_sel_a_bit1_out, osc_sel_a_bit0_out, osc_sel_b_bit1_out, osc_sel_b_bit0_out} <= sel_in;
   end
endmodule
`default_nettype wire

// [test/test_nco_select_and_overrange_pins.sv]
// Self-checking bench for oscillator select and overrange flags.
// Drives nsop_top over Avalon-MM; the host model drives the select pins.
`timescale 1ns/1ns
`default_nettype none
module test_nco_select_and_overrange_pins;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [3:0] addr = 4'h0;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata, pha, phb, q;
   logic wait_s, mix_en, irq, fa1, fa2, fb1, fb2, s_a0, s_a1, s_b0, s_b1;
   logic [11:0] smp_a = 12'h000;
   logic [11:0] smp_b = 12'h000;
   logic [15:0] fcnt = 16'h0;
   nsop_pkg::nsop_sel_type sel_req = '0;
   int mismatches = 0;
   int n_compared = 0;
   int cyc = 0;
   initial forever #5 clk_sys_in = !clk_sys_in;
   nsop_top dut_u (.clk_sys_in, .reset_n_in, .avs_address_in(addr), .avs_read_in(rd_s),
      .avs_write_in(wr_s), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s), .osc_sel_a_bit0_in(s_a0),
      .osc_sel_a_bit1_in(s_a1), .osc_sel_b_bit0_in(s_b0), .osc_sel_b_bit1_in(s_b1),
      .sample_a_in(smp_a), .sample_b_in(smp_b), .mix_phase_a_out(pha),
      .mix_phase_b_out(phb), .mix_enable_out(mix_en), .ovr_flag_a_first_out(fa1),
      .ovr_flag_a_second_out(fa2), .ovr_flag_b_first_out(fb1),
      .ovr_flag_b_second_out(fb2), .irq_out(irq));
   nsop_host_model host_u (.clk_sys_in, .sel_in(sel_req), .osc_sel_a_bit0_out(s_a0),
      .osc_sel_a_bit1_out(s_a1), .osc_sel_b_bit0_out(s_b0), .osc_sel_b_bit1_out(s_b1));
   // Cycles each flag spends high
   always @(negedge clk_sys_in)
      fcnt <= fcnt + {3'h0, fa1, 3'h0, fa2, 3'h0, fb1, 3'h0, fb2};
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest seen low at a falling edge, then dropped at the next rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      addr <= a;
      wdata <= d;
      wr_s <= w;
      rd_s <= !w;
      @(negedge clk_sys_in);
      while (wait_s !== 1'b0)
         @(negedge clk_sys_in);
      q = rdata;
      @(posedge clk_sys_in);
      rd_s <= 1'b0;
      wr_s <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic irqchk(input logic e);
      @(negedge clk_sys_in);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   task automatic pulse(input logic [11:0] a, b, input int len, input logic [15:0] exp);
      @(posedge clk_sys_in);
      fcnt = 16'h0;
      smp_a <= a;
      smp_b <= b;
      repeat (len) @(posedge clk_sys_in);
      smp_a <= 12'h000;
      smp_b <= 12'h000;
      repeat (12) @(posedge clk_sys_in);
      chk({16'h0, fcnt}, {16'h0, exp});
   endtask
   task automatic t_regs;
      rdc(nsop_pkg::REG_CTRL, nsop_pkg::CTRL_RESET);
      rdc(nsop_pkg::REG_THR, 32'h07ff_07ff);
      rdc(nsop_pkg::REG_HOLD, 32'h0000_0001);
      rdc(4'h6, 32'h0);
   endtask
   task automatic t_ovr;
      bus(1'b1, nsop_pkg::REG_THR, 32'h01f4_0064);
      bus(1'b1, nsop_pkg::REG_HOLD, 32'h0000_0004);
      pulse(12'h065, 12'h000, 1, 16'h4000);
      pulse(12'hf9b, 12'h000, 1, 16'h4000);
      pulse(12'h064, 12'hf9c, 1, 16'h0000);
      pulse(12'h065, 12'h000, 6, 16'h9000);
      pulse(12'h800, 12'h1f5, 1, 16'h4444);
      pulse(12'h1f5, 12'h065, 2, 16'h5550);
      irqchk(1'b0);
      rdc(nsop_pkg::REG_IRQ_STAT, 32'h0000_000f);
      bus(1'b1, nsop_pkg::REG_IRQ_MASK, 32'h0000_0008);
      irqchk(1'b1);
      bus(1'b1, nsop_pkg::REG_IRQ_STAT, 32'h0000_0008);
      irqchk(1'b0);
      rdc(nsop_pkg::REG_IRQ_STAT, 32'h0000_0007);
   endtask
   task automatic t_sel;
      logic [31:0] a0, b0, p1;
      int t1;
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, nsop_pkg::REG_FREQ0 + 4'(k), 32'h100 << k);
         bus(1'b1, nsop_pkg::REG_FREQ0 + 4'(k + 4), 32'h10000 << k);
      end
      bus(1'b1, nsop_pkg::REG_CTRL, 32'h0000_0003);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk_sys_in);
         sel_req <= {2'(k), 2'(3 - k)};
         repeat (8) @(posedge clk_sys_in);
         @(negedge clk_sys_in);
         a0 = pha;
         b0 = phb;
         @(negedge clk_sys_in);
         chk(pha - a0, 32'h100 << k);
         chk(phb - b0, 32'h10000 << (3 - k));
         rdc(nsop_pkg::REG_STATUS, {20'h0, 2'(k), 2'(3 - k), 8'h00});
      end
      // Leave oscillator 1, come back, phase must have kept running
      @(posedge clk_sys_in);
      sel_req <= 4'h4;
      repeat (8) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      p1 = pha;
      t1 = cyc;
      @(posedge clk_sys_in);
      sel_req <= 4'h8;
      repeat (8) @(posedge clk_sys_in);
      sel_req <= 4'h4;
      repeat (8) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      chk(pha, p1 + 32'h200 * 32'(cyc - t1));
      bus(1'b1, nsop_pkg::REG_CTRL, 32'h0000_0092);
      @(posedge clk_sys_in);
      sel_req <= 4'hf;
      repeat (8) @(posedge clk_sys_in);
      rdc(nsop_pkg::REG_STATUS, 32'h0000_0600);
      bus(1'b1, nsop_pkg::REG_CTRL, 32'h0000_0001);
      @(negedge clk_sys_in);
      chk({31'h0, mix_en}, 32'h0);
      chk(pha, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      t_regs();
      t_ovr();
      t_sel();
      print_verdict();
   end
endmodule
`default_nettype wire
